/* hdl/dbgcf_regs.sv */
// dbgcf_regs: comparator C address pattern, comparator A/B direction
// qualifiers and the capture buffer read ports of an on-chip debug unit.
// assumes the watched cpu bus and capture source run on sys_clk_i.
//
// Contract
// [RL1] low byte sets address bits 7..0 pattern
// [RL2] high byte sets address bits 15..8
// [RL3] high read port returns word bits 15..8
// [RL4] event-only modes read high port as zero
// [RL5] low read returns byte, advances pointer
// [RL6] software reads high before low byte
// [RL7] event-only software may read low only
// [RL8] A bit7 enables direction in A match
// [RL9] A bit6 picks write(0) or read(1)
// [RL10] B bit7 enables direction in B match
// [RL11] B bit6 picks write(0) or read(1)
// [RL12] full modes use A direction bits only
// [RL13] end-run reset keeps register contents; the mode register still clears on it
// [RL14] enable forced low while device secured
// [RL15] direction bits 5..0 read zero
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dbgcf_regs #(
    parameter int unsigned DEPTH = dbgcf_pkg::CAPTURE_DEPTH,
    parameter int unsigned AW    = 3
) (
    input  wire logic        sys_clk_i,     // 40 MHz bus clock
    input  wire logic        resetn_i,      // reset, active low; async for mode and outputs, sync for comparator and pointer registers
    input  wire logic [3:0]  reg_addr_i,    // register offset
    input  wire logic [7:0]  reg_wdata_i,   // write data
    input  wire logic        reg_wr_i,      // write strobe
    input  wire logic        reg_rd_i,      // read strobe
    output var  logic [7:0]  reg_rdata_o,   // read data, cycle after strobe
    input  wire logic        secure_i,      // device secured level
    input  wire logic        end_run_i,     // reset ends an end-trigger run
    input  wire logic        end_trig_i,    // end-triggering selected
    input  wire logic        bus_valid_i,   // watched bus cycle present
    input  wire logic [15:0] bus_addr_i,    // watched address
    input  wire logic        bus_read_i,    // watched direction, 1 = read
    input  wire logic        cap_push_i,    // store a capture word
    input  wire logic [15:0] cap_word_i,    // capture word
    output var  logic        match_a_o,     // comparator A qualified match
    output var  logic        match_b_o,     // comparator B qualified match
    output var  logic        match_c_o,     // comparator C address match
    output var  logic        cap_empty_o    // capture buffer empty
);
    logic [7:0]  cmp_c_high, next_cmp_c_high;
    logic [7:0]  cmp_c_low, next_cmp_c_low;
    logic [1:0]  cmp_a_dir, next_cmp_a_dir;
    logic [1:0]  cmp_b_dir, next_cmp_b_dir;
    logic [2:0]  mode_ctl, next_mode_ctl;
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0]   count, next_count;
    logic [7:0]  rdata, next_rdata;
    logic        ma, mb, mc, next_ma, next_mb, next_mc;
    logic        keep_q;
    logic [15:0] cap_rd_word;
    logic        module_enable;
    logic        event_only;
    logic        full_mode;
    logic        pop;
    logic        push;
    logic        cap_valid;
    logic [AW-1:0] mem_rd_addr;

    assign module_enable = mode_ctl[2];
    assign event_only    = mode_ctl[1];
    assign full_mode     = mode_ctl[0];
    assign cap_valid     = (count != '0);
    assign pop  = reg_rd_i && (reg_addr_i == dbgcf_pkg::OFF_CAP_LOW_READ) && cap_valid; // RL5
    assign push = cap_push_i && (count != (AW+1)'(DEPTH));
    assign mem_rd_addr = pop ? next_rd_ptr : rd_ptr;

    dbgcf_capture_mem #(
        .WIDTH (dbgcf_pkg::CAPTURE_WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (push),
        .wr_addr_i (wr_ptr),
        .wr_data_i (cap_word_i),
        .rd_addr_i (mem_rd_addr),
        .rd_data_o (cap_rd_word)
    );

    // register writes and capture pointers
    always_comb begin
        next_cmp_c_high = cmp_c_high;
        next_cmp_c_low  = cmp_c_low;
        next_cmp_a_dir  = cmp_a_dir;
        next_cmp_b_dir  = cmp_b_dir;
        next_mode_ctl   = mode_ctl;
        next_wr_ptr     = wr_ptr;
        next_rd_ptr     = rd_ptr;
        next_count      = count;
        if (reg_wr_i) begin
            case (reg_addr_i)
                dbgcf_pkg::OFF_CMP_C_HIGH: next_cmp_c_high = reg_wdata_i; // RL2
                dbgcf_pkg::OFF_CMP_C_LOW:  next_cmp_c_low  = reg_wdata_i; // RL1
                dbgcf_pkg::OFF_CMP_A_DIR:
                    next_cmp_a_dir = reg_wdata_i[dbgcf_pkg::DIR_EN_BIT:dbgcf_pkg::DIR_VAL_BIT];
                dbgcf_pkg::OFF_CMP_B_DIR:
                    next_cmp_b_dir = reg_wdata_i[dbgcf_pkg::DIR_EN_BIT:dbgcf_pkg::DIR_VAL_BIT];
                dbgcf_pkg::OFF_MODE_CTL: begin
                    next_mode_ctl = {reg_wdata_i[dbgcf_pkg::MODE_ENABLE_BIT],
                                     reg_wdata_i[dbgcf_pkg::MODE_EVENT_BIT],
                                     reg_wdata_i[dbgcf_pkg::MODE_FULL_BIT]};
                end
                default: ;
            endcase
        end
        if (secure_i) begin
            next_mode_ctl[2] = 1'b0; // RL14
        end
        if (push) begin
            next_wr_ptr = wr_ptr + AW'(1);
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + AW'(1); // RL5
        end
        case ({push, pop})
            2'b10:   next_count = count + (AW+1)'(1);
            2'b01:   next_count = count - (AW+1)'(1);
            default: next_count = count;
        endcase
    end

    // end-run reset: state holds through the reset when the run ended there.
    // the flag freezes while reset is low; the mode register clears at once,
    // so sampling it during reset would lose the decision of the last edge
    always_ff @(posedge sys_clk_i) begin
        if (resetn_i) begin
            keep_q <= end_trig_i && module_enable; // RL13
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_ctl <= 3'b000;
        end else begin
            mode_ctl <= next_mode_ctl;
        end
    end

    // registers that survive an end-run reset are reset synchronously instead
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i && !(end_run_i && keep_q)) begin // RL13
            cmp_c_high <= dbgcf_pkg::RESET_BYTE;
            cmp_c_low  <= dbgcf_pkg::RESET_BYTE;
            cmp_a_dir  <= 2'b00;
            cmp_b_dir  <= 2'b00;
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
        end else if (resetn_i) begin
            cmp_c_high <= next_cmp_c_high;
            cmp_c_low  <= next_cmp_c_low;
            cmp_a_dir  <= next_cmp_a_dir;
            cmp_b_dir  <= next_cmp_b_dir;
            wr_ptr     <= next_wr_ptr;
            rd_ptr     <= next_rd_ptr;
            count      <= next_count;
        end
    end

    // comparators and read data
    always_comb begin
        next_mc = bus_valid_i && (bus_addr_i == {cmp_c_high, cmp_c_low}); // RL1 RL2
        next_ma = bus_valid_i && (!cmp_a_dir[1] || (cmp_a_dir[0] == bus_read_i)); // RL8 RL9
        if (full_mode) begin
            next_mb = next_ma; // RL12
        end else begin
            next_mb = bus_valid_i && (!cmp_b_dir[1] || (cmp_b_dir[0] == bus_read_i)); // RL10 RL11
        end
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                dbgcf_pkg::OFF_CMP_C_HIGH: next_rdata = cmp_c_high;
                dbgcf_pkg::OFF_CMP_C_LOW:  next_rdata = cmp_c_low;
                dbgcf_pkg::OFF_CAP_HIGH_READ:
                    next_rdata = event_only ? 8'h00 : cap_rd_word[15:8]; // RL3 RL4
                dbgcf_pkg::OFF_CAP_LOW_READ: next_rdata = cap_rd_word[7:0]; // RL5
                dbgcf_pkg::OFF_CMP_A_DIR:  next_rdata = {cmp_a_dir, 6'h00}; // RL15
                dbgcf_pkg::OFF_CMP_B_DIR:  next_rdata = {cmp_b_dir, 6'h00}; // RL15
                dbgcf_pkg::OFF_MODE_CTL:   next_rdata = {mode_ctl[2], 5'h00, mode_ctl[1:0]};
                dbgcf_pkg::OFF_STATUS:     next_rdata = {3'h0, count[3:0] & 4'hF, 1'b0};
                default:                   next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata <= 8'h00;
            ma    <= 1'b0;
            mb    <= 1'b0;
            mc    <= 1'b0;
        end else begin
            rdata <= next_rdata;
            ma    <= next_ma;
            mb    <= next_mb;
            mc    <= next_mc;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_empty_o <= 1'b1;
        end else begin
            cap_empty_o <= (next_count == '0);
        end
    end

    assign reg_rdata_o = rdata;
    assign match_a_o   = ma;
    assign match_b_o   = mb;
    assign match_c_o   = mc;

    a_enable_secure: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        secure_i |=> !mode_ctl[2]) else $error("enable set while secured"); // RL14
    a_dir_a_match: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (bus_valid_i && cmp_a_dir == 2'b11 && !bus_read_i) |=> !match_a_o)
        else $error("comparator A matched wrong direction"); // RL9
    a_dir_a_ignore: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (bus_valid_i && !cmp_a_dir[1]) |=> match_a_o)
        else $error("comparator A direction not ignored"); // RL8
    a_dir_b_match: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (bus_valid_i && !full_mode && cmp_b_dir == 2'b10 && bus_read_i) |=> !match_b_o)
        else $error("comparator B matched wrong direction"); // RL11
    a_dir_b_ignore: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (bus_valid_i && !full_mode && !cmp_b_dir[1]) |=> match_b_o)
        else $error("comparator B direction not ignored"); // RL10
    a_full_uses_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        full_mode |=> (match_b_o == match_a_o))
        else $error("full mode B differs from A"); // RL12
    a_c_addr_match: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (bus_valid_i && bus_addr_i == {cmp_c_high, cmp_c_low}) |=> match_c_o)
        else $error("comparator C missed address"); // RL1
    a_high_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == dbgcf_pkg::OFF_CAP_HIGH_READ && event_only)
        |=> reg_rdata_o == 8'h00) else $error("high port nonzero in event mode"); // RL4
    a_low_advance: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (pop && !push) |=> count == $past(count) - 1)
        else $error("low read did not advance"); // RL5
    a_dir_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == dbgcf_pkg::OFF_CMP_A_DIR) |=> reg_rdata_o[5:0] == 6'h00)
        else $error("unimplemented bits nonzero"); // RL15

    // comparator C pattern checks
    a_c_addr_miss: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL1
        (bus_valid_i && bus_addr_i != {cmp_c_high, cmp_c_low}) |=> !match_c_o)
        else $error("comparator C matched wrong address");

    a_c_low_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL1
        (reg_wr_i && reg_addr_i == dbgcf_pkg::OFF_CMP_C_LOW)
        |=> cmp_c_low == $past(reg_wdata_i))
        else $error("comparator C low byte not written");

    a_c_high_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL2
        (reg_wr_i && reg_addr_i == dbgcf_pkg::OFF_CMP_C_HIGH)
        |=> cmp_c_high == $past(reg_wdata_i))
        else $error("comparator C high byte not written");

    // direction qualifier checks
    a_dir_a_hit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL9
        (bus_valid_i && cmp_a_dir == 2'b11 && bus_read_i) |=> match_a_o)
        else $error("comparator A missed read cycle");

    a_dir_a_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL9
        (bus_valid_i && cmp_a_dir == 2'b10 && !bus_read_i) |=> match_a_o)
        else $error("comparator A missed write cycle");

    a_dir_a_used: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL8
        (bus_valid_i && cmp_a_dir == 2'b10 && bus_read_i) |=> !match_a_o)
        else $error("comparator A direction not used");

    a_dir_b_hit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL11
        (bus_valid_i && !full_mode && cmp_b_dir == 2'b11 && bus_read_i) |=> match_b_o)
        else $error("comparator B missed read cycle");

    a_dir_b_used: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL10
        (bus_valid_i && !full_mode && cmp_b_dir == 2'b11 && !bus_read_i) |=> !match_b_o)
        else $error("comparator B direction not used");

    a_full_ignores_b: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL12
        (bus_valid_i && full_mode && cmp_a_dir == 2'b00) |=> match_b_o)
        else $error("full mode used B direction bits");

    a_no_cycle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL8
        !bus_valid_i |=> (!match_a_o && !match_b_o && !match_c_o))
        else $error("match without a bus cycle");

    a_dir_a_write_bits: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL8
        (reg_wr_i && reg_addr_i == dbgcf_pkg::OFF_CMP_A_DIR)
        |=> cmp_a_dir == $past(reg_wdata_i[7:6]))
        else $error("comparator A direction bits not written");

    a_b_dir_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL15
        (reg_rd_i && reg_addr_i == dbgcf_pkg::OFF_CMP_B_DIR) |=> reg_rdata_o[5:0] == 6'h00)
        else $error("unimplemented B bits nonzero");

    // capture read port checks
    a_high_word: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL3
        (reg_rd_i && reg_addr_i == dbgcf_pkg::OFF_CAP_HIGH_READ && !event_only)
        |=> reg_rdata_o == $past(cap_rd_word[15:8]))
        else $error("high port wrong byte");

    a_low_word: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL5
        (reg_rd_i && reg_addr_i == dbgcf_pkg::OFF_CAP_LOW_READ)
        |=> reg_rdata_o == $past(cap_rd_word[7:0]))
        else $error("low port wrong byte");

    a_low_pointer: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RL5
        pop |=> rd_ptr == $past(rd_ptr) + AW'(1))
        else $error("read pointer did not advance");

    // end-run reset checks: these run while reset is low
    a_keep_reset: assert property (@(posedge sys_clk_i) // RL13
        (!resetn_i && end_run_i && keep_q) |=> cmp_c_low == $past(cmp_c_low))
        else $error("end-run reset changed comparator");

    a_clear_reset: assert property (@(posedge sys_clk_i) // RL13
        (!resetn_i && !(end_run_i && keep_q)) |=> cmp_c_low == dbgcf_pkg::RESET_BYTE)
        else $error("plain reset kept comparator");
endmodule : dbgcf_regs
`default_nettype wire

/* hdl/dbgcf_pkg.sv */
// dbgcf_pkg: register offsets, field positions, reset values and modes of the
// comparator/capture-buffer register slice. Used with scoped names only.
package dbgcf_pkg;
    localparam logic [3:0] OFF_CMP_C_HIGH     = 4'h4;
    localparam logic [3:0] OFF_CMP_C_LOW      = 4'h5;
    localparam logic [3:0] OFF_CAP_HIGH_READ  = 4'h6;
    localparam logic [3:0] OFF_CAP_LOW_READ   = 4'h7;
    localparam logic [3:0] OFF_CMP_A_DIR      = 4'h8;
    localparam logic [3:0] OFF_CMP_B_DIR      = 4'h9;
    localparam logic [3:0] OFF_MODE_CTL       = 4'hA;
    localparam logic [3:0] OFF_STATUS         = 4'hB;

    localparam int unsigned DIR_EN_BIT        = 7;
    localparam int unsigned DIR_VAL_BIT       = 6;
    localparam int unsigned MODE_ENABLE_BIT   = 7;
    localparam int unsigned MODE_EVENT_BIT    = 1;
    localparam int unsigned MODE_FULL_BIT     = 0;

    localparam logic [7:0] RESET_BYTE         = 8'h00;
    localparam logic [7:0] DIR_WRITE_MASK     = 8'hC0;
    localparam logic [7:0] MODE_WRITE_MASK    = 8'h83;

    localparam int unsigned CAPTURE_DEPTH     = 8;
    localparam int unsigned CAPTURE_WIDTH     = 16;

    typedef enum logic [1:0] {
        DBGCF_RD_IDLE = 2'b00,
        DBGCF_RD_HOLD = 2'b01
    } dbgcf_rd_state_e;
endpackage : dbgcf_pkg

/* hdl/dbgcf_capture_mem.sv */
// dbgcf_capture_mem: capture word storage, registered read port.
// assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dbgcf_capture_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    input  wire logic             sys_clk_i,  // bus clock
    input  wire logic             wr_en_i,    // store a word
    input  wire logic [AW-1:0]    wr_addr_i,  // write slot
    input  wire logic [WIDTH-1:0] wr_data_i,  // word to store
    input  wire logic [AW-1:0]    rd_addr_i,  // read slot
    output var  logic [WIDTH-1:0] rd_data_o   // registered word
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : dbgcf_capture_mem
`default_nettype wire

/* tb/dbgcf_cpu_model.sv */
// dbgcf_cpu_model: watched cpu bus and capture source facing dbgcf_regs.
// assumes the bench calls its tasks; it drives only right after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dbgcf_cpu_model (
    input  wire logic        sys_clk_i,   // bus clock
    output var  logic        bus_valid_o, // bus cycle present
    output var  logic [15:0] bus_addr_o,  // watched address
    output var  logic        bus_read_o,  // 1 = read cycle
    output var  logic        cap_push_o,  // store a capture word
    output var  logic [15:0] cap_word_o   // capture word
);
    initial begin
        bus_valid_o = 1'b0;
        bus_addr_o  = 16'h0000;
        bus_read_o  = 1'b0;
        cap_push_o  = 1'b0;
        cap_word_o  = 16'h0000;
    end
    // released lines show the inverse, so a stale value cannot pass
    task automatic cycle(input logic [15:0] a, input logic r);
        @(posedge sys_clk_i);
        bus_valid_o <= 1'b1;
        bus_addr_o  <= a;
        bus_read_o  <= r;
        @(posedge sys_clk_i);
        bus_valid_o <= 1'b0;
        bus_addr_o  <= ~a;
        bus_read_o  <= ~r;
        #1;
    endtask : cycle
    task automatic push(input logic [15:0] w);
        @(posedge sys_clk_i);
        cap_push_o <= 1'b1;
        cap_word_o <= w;
        @(posedge sys_clk_i);
        cap_push_o <= 1'b0;
        cap_word_o <= ~w;
    endtask : push
endmodule : dbgcf_cpu_model
`default_nettype wire

/* tb/debug_comparator_fifo_regs_bench.sv */
// debug_comparator_fifo_regs_bench: register-port tests of dbgcf_regs.
// assumes dbgcf_cpu_model drives the watched bus and the capture source.
`timescale 1ns/1ps
`default_nettype none
module debug_comparator_fifo_regs_bench;
    logic        sys_clk_i   = 1'b0;
    logic        resetn_i    = 1'b0;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        secure_i    = 1'b0;
    logic        end_run_i   = 1'b0;
    logic        end_trig_i  = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        bus_valid, bus_read, cap_push, match_a_o, match_b_o, match_c_o, cap_empty_o;
    logic [15:0] bus_addr, cap_word;
    logic [7:0]  ctl;
    int          n_errors = 0;
    int          checked  = 0;
    int          cyc      = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    dbgcf_cpu_model cpu (.sys_clk_i(sys_clk_i), .bus_valid_o(bus_valid), .bus_addr_o(bus_addr),
        .bus_read_o(bus_read), .cap_push_o(cap_push), .cap_word_o(cap_word));
    dbgcf_regs dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .secure_i(secure_i), .end_run_i(end_run_i),
        .end_trig_i(end_trig_i), .bus_valid_i(bus_valid), .bus_addr_i(bus_addr),
        .bus_read_i(bus_read), .cap_push_i(cap_push), .cap_word_i(cap_word),
        .match_a_o(match_a_o), .match_b_o(match_b_o), .match_c_o(match_c_o),
        .cap_empty_o(cap_empty_o));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(what, {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rdc
    task automatic rst();
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
    endtask : rst

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        rst();
        rdc("c high reset", 4'h4, 8'h00);
        rdc("c low reset", 4'h5, 8'h00);
        rdc("a dir reset", 4'h8, 8'h00);
        rdc("b dir reset", 4'h9, 8'h00);
        rdc("unmapped", 4'hF, 8'h00);
        chk("empty after reset", {15'h0000, cap_empty_o}, 16'h0001);
        $display("test reset values done");
        wr(4'h4, 8'h12);
        wr(4'h5, 8'hA5);
        rdc("c low", 4'h5, 8'hA5);
        cpu.cycle(16'h12A5, 1'b0);
        chk("c match", {15'h0000, match_c_o}, 16'h0001);
        cpu.cycle(16'h12A4, 1'b1);
        chk("c low miss", {15'h0000, match_c_o}, 16'h0000);
        cpu.cycle(16'h13A5, 1'b0);
        chk("c high miss", {15'h0000, match_c_o}, 16'h0000);
        $display("test comparator c done");
        wr(4'h8, 8'hFF);
        wr(4'h9, 8'hFF);
        rdc("a dir bits", 4'h8, 8'hC0);
        rdc("b dir bits", 4'h9, 8'hC0);
        for (int k = 0; k < 16; k++) begin
            ctl = {k[2:1], 6'h00};
            wr(4'h8, k[3] ? 8'h00 : ctl);
            wr(4'h9, k[3] ? ctl : 8'h00);
            cpu.cycle(16'h0000, k[0]);
            chk(k[3] ? "b dir match" : "a dir match", {15'h0000, k[3] ? match_b_o : match_a_o},
                {15'h0000, !ctl[7] || (ctl[6] == k[0])});
        end
        $display("test direction done");
        wr(4'h8, 8'h80);
        wr(4'h9, 8'hC0);
        wr(4'hA, 8'h81);
        cpu.cycle(16'h0000, 1'b0);
        chk("full b write", {15'h0000, match_b_o}, 16'h0001);
        cpu.cycle(16'h0000, 1'b1);
        chk("full b read", {15'h0000, match_b_o}, 16'h0000);
        wr(4'hA, 8'h00);
        $display("test full mode done");
        cpu.push(16'h1234);
        cpu.push(16'hABCD);
        rdc("high word 0", 4'h6, 8'h12);
        rdc("low word 0", 4'h7, 8'h34);
        rdc("high word 1", 4'h6, 8'hAB);
        rdc("low word 1", 4'h7, 8'hCD);
        chk("empty after pops", {15'h0000, cap_empty_o}, 16'h0001);
        wr(4'hA, 8'h02);
        cpu.push(16'h5678);
        cpu.push(16'h9A0F);
        rdc("status count", 4'hB, 8'h04);
        rdc("event high", 4'h6, 8'h00);
        rdc("event low 0", 4'h7, 8'h78);
        rdc("event low 1", 4'h7, 8'h0F);
        $display("test capture done");
        wr(4'hA, 8'h80);
        rdc("enable set", 4'hA, 8'h80);
        secure_i <= 1'b1;
        rdc("enable dropped", 4'hA, 8'h00);
        wr(4'hA, 8'h80);
        rdc("enable secured", 4'hA, 8'h00);
        secure_i <= 1'b0;
        $display("test secure done");
        wr(4'h5, 8'h5A);
        wr(4'hA, 8'h80);
        end_trig_i <= 1'b1;
        end_run_i  <= 1'b1;
        rst();
        rdc("kept c low", 4'h5, 8'h5A);
        rdc("kept a dir", 4'h8, 8'h80);
        end_run_i <= 1'b0;
        rst();
        rdc("cleared c low", 4'h5, 8'h00);
        $display("test end-run reset done");
        wrap_up();
    end
endmodule : debug_comparator_fifo_regs_bench
`default_nettype wire
